// >>> rtl/dcc_dma_channels.sv
/*
  eight-channel dma engine with its per-channel register set, reached over
  avalon-mm, moving items between peripheral data registers and memory.
  assumes peripheral requests and the system bus answer are on the same clock;
  the bus answers each request with one ack cycle.
*/
`default_nettype none
module dcc_dma_channels (
  input wire logic clock,
  input wire logic reset,
  // avalon-mm register slave
  input wire logic [dcc_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // peripheral request levels and served pulses
  input wire logic [dcc_pkg::NUM_CH-1:0] periph_req,
  output logic [dcc_pkg::NUM_CH-1:0] periph_served,
  // system bus master
  output dcc_pkg::dcc_mreq_t mreq,
  input wire dcc_pkg::dcc_mrsp_t mrsp,
  // per-channel interrupt lines
  output logic [dcc_pkg::NUM_CH-1:0] chan_irq
);
  import dcc_pkg::*;

  // aligned address for an access width
  function automatic logic [31:0] align_addr(input logic [31:0] a, input logic [1:0] w);
    logic [31:0] r;
    r = a;
    if (w == W16) begin
      r[0] = 1'b0;
    end else if (w != W8) begin
      r[1:0] = 2'b00;
    end
    return r;
  endfunction

  // byte step for an access width
  function automatic logic [31:0] step_bytes(input logic [1:0] w);
    logic [31:0] r;
    r = 32'h0000_0004;
    if (w == W8) begin
      r = 32'h0000_0001;
    end else if (w == W16) begin
      r = 32'h0000_0002;
    end
    return r;
  endfunction

  // channel block base
  function automatic logic [7:0] ch_base(input int i);
    return OFS_CH0 + 8'(i) * CH_STRIDE;
  endfunction

  // programmed state per channel
  dcc_setup_t setup_q [NUM_CH]; // setup words
  logic [15:0] count_q [NUM_CH]; // items still outstanding
  logic [15:0] reload_q [NUM_CH]; // last programmed count
  logic [31:0] pptr_q [NUM_CH]; // programmed peripheral pointer
  logic [31:0] mptr_q [NUM_CH]; // programmed memory pointer
  logic [31:0] pcur_q [NUM_CH]; // working peripheral address
  logic [31:0] mcur_q [NUM_CH]; // working memory address
  // flags, three bits per channel (a nibble each in the status word)
  logic [NUM_CH-1:0] done_q, half_q, fault_q;

  // bus slave state
  logic wait_q; // waitrequest
  logic [31:0] rdata_q; // read data
  logic acc_wr; // write completes this edge

  // engine state
  dcc_state_t state_q;
  logic [2:0] cur_q; // channel being served
  logic [31:0] data_q; // item in flight
  dcc_mreq_t mreq_q; // bus request
  logic [NUM_CH-1:0] served_q; // served pulses
  logic [NUM_CH-1:0] irq_q; // interrupt lines

  // engine events, valid in a bus-answer cycle (done on the write answer, fault on read or write)
  logic item_done; // item written without error
  logic item_fault; // bus error on read or write
  logic [15:0] cnt_next; // count after this item

  // arbitration result
  logic grant_valid;
  logic [2:0] grant_ch;

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign mreq = mreq_q;
  assign periph_served = served_q;
  assign chan_irq = irq_q;

  // write takes effect at the edge where waitrequest is low
  assign acc_wr = avs_write && !wait_q;
  assign item_done = (state_q == ST_WRITE) && mrsp.ack && !mrsp.err;
  assign item_fault = (state_q != ST_IDLE) && (state_q != ST_GAP) && mrsp.ack && mrsp.err;
  assign cnt_next = count_q[cur_q] - 16'h0001;

  // pick highest level, lowest channel on a tie
  always_comb begin
    grant_valid = 1'b0;
    grant_ch = 3'h0;
    for (int i = 0; i < NUM_CH; i++) begin
      // enabled, nonzero count, and a request or copy mode
      if (setup_q[i].chan_on && (count_q[i] != 16'h0000) &&
          (setup_q[i].copy_mode || periph_req[i])) begin
        // strictly higher level wins, so earlier channel keeps ties
        if (!grant_valid ||
            setup_q[i].channel_priority > setup_q[grant_ch].channel_priority) begin
          grant_valid = 1'b1;
          grant_ch = 3'(i);
        end
      end
    end
  end

  // register read value
  function automatic logic [31:0] read_value(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == OFS_FLAGS) begin
      for (int i = 0; i < NUM_CH; i++) begin
        r[4*i+FLG_ANY] = done_q[i] | half_q[i] | fault_q[i];
        r[4*i+FLG_DONE] = done_q[i];
        r[4*i+FLG_HALF] = half_q[i];
        r[4*i+FLG_FAULT] = fault_q[i];
      end
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (a == ch_base(i) + OFS_SETUP) begin
        r = {17'h00000, setup_q[i]}; // high bits read zero
      end else if (a == ch_base(i) + OFS_COUNT) begin
        r = {16'h0000, count_q[i]};
      end else if (a == ch_base(i) + OFS_PPTR) begin
        r = pptr_q[i];
      end else if (a == ch_base(i) + OFS_MPTR) begin
        r = mptr_q[i];
      end
    end
    return r;
  endfunction

  // avalon handshake: one wait cycle, then completion
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wait_q <= 1'b1;
      rdata_q <= RESET_WORD;
    end else if (wait_q && (avs_read || avs_write)) begin
      // request seen: answer next cycle
      wait_q <= 1'b0;
      rdata_q <= avs_read ? read_value(avs_address) : 32'h0000_0000;
    end else begin
      // completion edge or idle
      wait_q <= 1'b1;
    end
  end

  // per-channel registers, software writes then engine updates
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_CH; i++) begin
        setup_q[i] <= dcc_setup_t'(RESET_WORD[SETUP_BITS-1:0]);
        count_q[i] <= 16'h0000;
        reload_q[i] <= 16'h0000;
        pptr_q[i] <= RESET_WORD;
        mptr_q[i] <= RESET_WORD;
        pcur_q[i] <= RESET_WORD;
        mcur_q[i] <= RESET_WORD;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (acc_wr && avs_address == ch_base(i) + OFS_SETUP) begin
          setup_q[i] <= dcc_setup_t'(avs_writedata[SETUP_BITS-1:0]);
          // turning on starts from the programmed pointers
          if (avs_writedata[0] && !setup_q[i].chan_on) begin
            pcur_q[i] <= pptr_q[i];
            mcur_q[i] <= mptr_q[i];
          end
        end
        // count writes ignored while on
        if (acc_wr && avs_address == ch_base(i) + OFS_COUNT && !setup_q[i].chan_on) begin
          count_q[i] <= avs_writedata[15:0];
          reload_q[i] <= avs_writedata[15:0];
        end
        if (acc_wr && avs_address == ch_base(i) + OFS_PPTR) begin
          pptr_q[i] <= avs_writedata;
          if (!setup_q[i].chan_on) begin
            pcur_q[i] <= avs_writedata;
          end
        end
        if (acc_wr && avs_address == ch_base(i) + OFS_MPTR) begin
          mptr_q[i] <= avs_writedata;
          if (!setup_q[i].chan_on) begin
            mcur_q[i] <= avs_writedata;
          end
        end
      end
      // item finished: count and addresses move on
      if (item_done) begin
        if (cnt_next == 16'h0000 && setup_q[cur_q].wrap_reload_mode) begin
          // circular: reload count and pointers, keep running
          count_q[cur_q] <= reload_q[cur_q];
          pcur_q[cur_q] <= pptr_q[cur_q];
          mcur_q[cur_q] <= mptr_q[cur_q];
        end else begin
          count_q[cur_q] <= cnt_next;
          if (setup_q[cur_q].periph_addr_step) begin
            pcur_q[cur_q] <= pcur_q[cur_q] + step_bytes(setup_q[cur_q].periph_width);
          end
          if (setup_q[cur_q].mem_addr_step) begin
            mcur_q[cur_q] <= mcur_q[cur_q] + step_bytes(setup_q[cur_q].mem_width);
          end
        end
      end
      // bus error switches the channel off
      if (item_fault) begin
        setup_q[cur_q].chan_on <= 1'b0;
      end
    end
  end

  // transfer sequencer: read source, write destination
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      cur_q <= 3'h0;
      data_q <= RESET_WORD;
      mreq_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (grant_valid) begin
            cur_q <= grant_ch;
            state_q <= ST_READ;
            mreq_q.req <= 1'b1;
            mreq_q.we <= 1'b0;
            mreq_q.wdata <= 32'h0000_0000;
            // source side per direction, aligned to its width
            if (setup_q[grant_ch].dir_from_mem) begin
              mreq_q.size <= setup_q[grant_ch].mem_width;
              mreq_q.addr <= align_addr(mcur_q[grant_ch], setup_q[grant_ch].mem_width);
            end else begin
              mreq_q.size <= setup_q[grant_ch].periph_width;
              mreq_q.addr <= align_addr(pcur_q[grant_ch], setup_q[grant_ch].periph_width);
            end
          end
        end
        ST_READ: begin
          if (mrsp.ack && mrsp.err) begin
            // read failed: drop the item
            mreq_q.req <= 1'b0;
            state_q <= ST_GAP;
          end else if (mrsp.ack) begin
            data_q <= mrsp.rdata;
            state_q <= ST_WRITE;
            mreq_q.we <= 1'b1;
            mreq_q.wdata <= mrsp.rdata;
            // destination side is the other one
            if (setup_q[cur_q].dir_from_mem) begin
              mreq_q.size <= setup_q[cur_q].periph_width;
              mreq_q.addr <= align_addr(pcur_q[cur_q], setup_q[cur_q].periph_width);
            end else begin
              mreq_q.size <= setup_q[cur_q].mem_width;
              mreq_q.addr <= align_addr(mcur_q[cur_q], setup_q[cur_q].mem_width);
            end
          end
        end
        ST_WRITE: begin
          if (mrsp.ack) begin
            mreq_q.req <= 1'b0;
            mreq_q.we <= 1'b0;
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          // lets the peripheral drop its request after the served pulse
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
          mreq_q <= '0;
        end
      endcase
    end
  end

  // served pulse to the requesting peripheral
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      served_q <= '0;
    end else begin
      served_q <= '0;
      if (item_done && !setup_q[cur_q].copy_mode) begin
        served_q[cur_q] <= 1'b1;
      end
    end
  end

  // flags: hardware set wins over software clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      done_q <= '0;
      half_q <= '0;
      fault_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        logic clr_done, clr_half, clr_fault, set_done, set_half, set_fault;
        // clear bits, global bit clears all three
        clr_done = acc_wr && avs_address == OFS_CLEAR &&
                   (avs_writedata[4*i+FLG_ANY] || avs_writedata[4*i+FLG_DONE]);
        clr_half = acc_wr && avs_address == OFS_CLEAR &&
                   (avs_writedata[4*i+FLG_ANY] || avs_writedata[4*i+FLG_HALF]);
        clr_fault = acc_wr && avs_address == OFS_CLEAR &&
                    (avs_writedata[4*i+FLG_ANY] || avs_writedata[4*i+FLG_FAULT]);
        // events of the channel being served
        set_done = item_done && cur_q == 3'(i) && cnt_next == 16'h0000;
        set_half = item_done && cur_q == 3'(i) &&
                   cnt_next == (reload_q[i] >> 1);
        set_fault = item_fault && cur_q == 3'(i);
        done_q[i] <= set_done | (done_q[i] & ~clr_done);
        half_q[i] <= set_half | (half_q[i] & ~clr_half);
        fault_q[i] <= set_fault | (fault_q[i] & ~clr_fault);
      end
    end
  end

  // interrupt lines gated by the enables
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        irq_q[i] <= (done_q[i] & setup_q[i].done_irq_on) |
                    (half_q[i] & setup_q[i].halfway_irq_on) |
                    (fault_q[i] & setup_q[i].fault_irq_on);
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/dcc_pkg.sv
/*
  constants, field layouts and carrier types for the eight-channel dma
  register set and transfer engine.
  assumes one 10 mhz clock domain and an avalon-mm register slave.
*/
`default_nettype none
package dcc_pkg;
  localparam int NUM_CH = 8; // channels 0 to 7
  localparam int AW = 8; // register byte address width
  // register map, byte addresses
  localparam logic [7:0] OFS_FLAGS = 8'h00; // flag_status_word, read only
  localparam logic [7:0] OFS_CLEAR = 8'h04; // flag clear word, write only
  localparam logic [7:0] OFS_CH0 = 8'h08; // first channel block
  localparam logic [7:0] CH_STRIDE = 8'h14; // bytes between channel blocks
  localparam logic [7:0] OFS_SETUP = 8'h00; // channel_setup_word
  localparam logic [7:0] OFS_COUNT = 8'h04; // items_remaining_count
  localparam logic [7:0] OFS_PPTR = 8'h08; // peripheral_side_pointer
  localparam logic [7:0] OFS_MPTR = 8'h0C; // memory_side_pointer
  // setup word field positions
  localparam int SETUP_BITS = 15; // bits 14:0 live, 31:15 read zero
  localparam logic [31:0] RESET_WORD = 32'h0000_0000; // all registers
  // flag positions inside a channel nibble of the status word
  localparam int FLG_ANY = 0;
  localparam int FLG_DONE = 1;
  localparam int FLG_HALF = 2;
  localparam int FLG_FAULT = 3;
  // access width codes
  localparam logic [1:0] W8 = 2'h0;
  localparam logic [1:0] W16 = 2'h1;
  localparam logic [1:0] W32 = 2'h2;

  // channel setup word, msb first
  typedef struct packed {
    logic copy_mode; // bit 14
    logic [1:0] channel_priority; // bits 13:12
    logic [1:0] mem_width; // bits 11:10
    logic [1:0] periph_width; // bits 9:8
    logic mem_addr_step; // bit 7
    logic periph_addr_step; // bit 6
    logic wrap_reload_mode; // bit 5
    logic dir_from_mem; // bit 4
    logic fault_irq_on; // bit 3
    logic halfway_irq_on; // bit 2
    logic done_irq_on; // bit 1
    logic chan_on; // bit 0
  } dcc_setup_t;

  // request toward the system bus
  typedef struct packed {
    logic req; // held until ack
    logic we; // 1 write, 0 read
    logic [1:0] size; // width code
    logic [31:0] addr; // aligned byte address
    logic [31:0] wdata; // write data, low bits used
  } dcc_mreq_t;

  // answer from the system bus
  typedef struct packed {
    logic ack; // one-cycle completion
    logic err; // with ack: bus error
    logic [31:0] rdata; // read data with ack
  } dcc_mrsp_t;

  // engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10,
    ST_GAP = 2'b11
  } dcc_state_t;
endpackage
`default_nettype wire

// >>> tb/dcc_bus_model.sv
/*
  system bus model: answers each engine request after lag stall cycles,
  logs writes. assumes the engine holds its request until ack.
*/
`default_nettype none
module dcc_bus_model (
  input wire logic clock,
  input wire logic reset,
  input wire dcc_pkg::dcc_mreq_t mreq,
  output dcc_pkg::dcc_mrsp_t mrsp,
  input wire logic [1:0] lag,
  input wire logic fail
);
  import dcc_pkg::*;
  logic [31:0] wa[$]; // written addresses
  logic [31:0] wd[$]; // written data
  int n_ack; // answered requests
  logic [1:0] wait_q; // stall cycles spent
  // read data made from the address so the bench can predict it
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      mrsp <= '0;
      wait_q <= 2'h0;
      n_ack <= 0;
    end else if (mreq.req && !mrsp.ack && wait_q >= lag) begin
      mrsp.ack <= 1'b1;
      mrsp.err <= fail;
      mrsp.rdata <= {~mreq.addr[15:0], mreq.addr[15:0]};
      wait_q <= 2'h0;
      n_ack <= n_ack + 1;
      if (mreq.we) begin
        wa.push_back(mreq.addr);
        wd.push_back(mreq.wdata);
      end
    end else begin
      mrsp.ack <= 1'b0;
      mrsp.err <= 1'b0;
      mrsp.rdata <= ~mrsp.rdata; // inverted every cycle outside an answer, so the last answer recurs every other cycle
      if (mreq.req && !mrsp.ack) wait_q <= wait_q + 2'h1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/dcc_dma_channels_monitor.sv
/*
  checker for the dma engine ports: register handshake, engine bus order.
  assumes it is bound into dcc_dma_channels by the bind below.
*/
`default_nettype none
module dcc_dma_channels_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [dcc_pkg::NUM_CH-1:0] periph_served,
  input wire dcc_pkg::dcc_mreq_t mreq,
  input wire dcc_pkg::dcc_mrsp_t mrsp
);
  import dcc_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic wr_ok; // clean destination write
  assign wr_ok = mrsp.ack && mreq.we && !mrsp.err;
  // source read answered without error
  sequence s_rd_ok;
    mreq.req && !mreq.we && mrsp.ack && !mrsp.err;
  endsequence
  // destination write answered
  sequence s_wr_end;
    mreq.req && mreq.we && mrsp.ack;
  endsequence
  AST_WAIT_ANS: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("register access not answered");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_HOLD: assert property (mreq.req && !mrsp.ack |=> mreq.req && $stable(mreq.addr))
    else $error("engine request not held");
  AST_PASS: assert property (s_rd_ok |=> mreq.we && mreq.wdata == $past(mrsp.rdata))
    else $error("read data not passed on");
  AST_GAP: assert property (s_wr_end |=> !mreq.req [*2])
    else $error("no gap after item");
  AST_ERR: assert property (mreq.req && mrsp.ack && mrsp.err |=> !mreq.req)
    else $error("item continued after error");
  AST_AL16: assert property (mreq.req && mreq.size == W16 |-> !mreq.addr[0])
    else $error("halfword access misaligned");
  AST_AL32: assert property (mreq.req && mreq.size[1] |-> mreq.addr[1:0] == 2'h0)
    else $error("word access misaligned");
  AST_SERVED: assert property (periph_served != '0 |-> $onehot(periph_served) && $past(wr_ok))
    else $error("served pulse without item");
endmodule
bind dcc_dma_channels dcc_dma_channels_monitor u_mon (
  .clock(clock), .reset(reset), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .periph_served(periph_served),
  .mreq(mreq), .mrsp(mrsp));
`default_nettype wire

// >>> tb/tb_dcc_dma_channels.sv
/*
  bench for the dma engine: avalon-mm tasks, one task per scenario.
  assumes the bus model on the engine side and the bound checker.
*/
`default_nettype none
module tb_dcc_dma_channels;
  timeunit 1ns;
  timeprecision 1ns;
  import dcc_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [NUM_CH-1:0] periph_req = '0;
  logic [NUM_CH-1:0] periph_served;
  logic [NUM_CH-1:0] chan_irq;
  logic [1:0] lag = 2'h0; // bus stall cycles
  logic fail = 1'b0; // bus error injection
  dcc_mreq_t mreq;
  dcc_mrsp_t mrsp;
  int n_mismatch = 0;
  int comparisons = 0;
  always #50 clock = ~clock;
  dcc_dma_channels u_dut (.clock(clock), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .periph_req(periph_req), .periph_served(periph_served), .mreq(mreq),
    .mrsp(mrsp), .chan_irq(chan_irq));
  dcc_bus_model u_bus (.clock(clock), .reset(reset), .mreq(mreq), .mrsp(mrsp),
    .lag(lag), .fail(fail));
  function automatic logic [7:0] ca(input int c, input logic [7:0] o);
    return 8'(OFS_CH0 + CH_STRIDE * c + o);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // one access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clock);
    // only the watchdog ends a wait that never completes
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    int n;
    n = 0;
    q = ~e;
    while (q !== e && n < 200) begin
      bus(1'b0, a, 32'h0, q);
      n++;
    end
  endtask
  task automatic wait_wr(input int k);
    int n;
    n = 0;
    while (u_bus.wa.size() < k && n < 500) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic t_regs;
    rdc(ca(0, OFS_SETUP), RESET_WORD, "setup");
    rdc(ca(0, OFS_COUNT), RESET_WORD, "count");
    rdc(ca(7, OFS_MPTR), RESET_WORD, "mptr");
    wr(ca(7, OFS_PPTR), 32'hA5A5_5A5A);
    rdc(ca(7, OFS_PPTR), 32'hA5A5_5A5A, "pptr");
    wr(ca(7, OFS_SETUP), 32'hFFFF_FFFE);
    rdc(ca(7, OFS_SETUP), 32'h0000_7FFE, "setup bits");
    wr(ca(7, OFS_SETUP), 32'h0);
    wr(8'hF0, 32'h1);
    rdc(8'hF0, 32'h0, "unmapped");
    wr(ca(1, OFS_COUNT), 32'h5);
    wr(ca(1, OFS_SETUP), 32'h1);
    wr(ca(1, OFS_COUNT), 32'h9);
    rdc(ca(1, OFS_COUNT), 32'h5, "locked count");
    wr(ca(1, OFS_SETUP), 32'h0);
    wr(ca(1, OFS_COUNT), 32'h1_FFFF);
    rdc(ca(1, OFS_COUNT), 32'hFFFF, "count range");
  endtask
  // peripheral to memory, stalled bus, unaligned pointers aligned to their widths
  task automatic t_p2m;
    int n0;
    n0 = u_bus.wa.size();
    wr(ca(0, OFS_PPTR), 32'h1003);
    wr(ca(0, OFS_MPTR), 32'h2001);
    wr(ca(0, OFS_COUNT), 32'h2);
    lag <= 2'h2;
    periph_req[0] <= 1'b1;
    wr(ca(0, OFS_SETUP), 32'h685);
    poll(ca(0, OFS_COUNT), 32'h0);
    repeat (20) @(posedge clock);
    chk("items", 32'(n0 + 2), 32'(u_bus.wa.size()));
    chk("dst0", 32'h2000, u_bus.wa[n0]);
    chk("dst1", 32'h2002, u_bus.wa[n0 + 1]);
    chk("data", 32'hEFFF_1000, u_bus.wd[n0 + 1]);
    rdc(OFS_FLAGS, 32'h7, "flags");
    chk("half irq", 32'h1, 32'(chan_irq));
    wr(OFS_CLEAR, 32'h4);
    wr(OFS_CLEAR, 32'h0);
    rdc(OFS_FLAGS, 32'h3, "clr half");
    chk("done irq off", 32'h0, 32'(chan_irq));
    wr(OFS_CLEAR, 32'h1);
    rdc(OFS_FLAGS, 32'h0, "clr all");
    periph_req[0] <= 1'b0;
    lag <= 2'h0;
    wr(ca(0, OFS_SETUP), 32'h0);
  endtask
  // memory to peripheral copy, circular reload
  task automatic t_copy;
    int n0;
    n0 = u_bus.wa.size();
    wr(ca(2, OFS_PPTR), 32'h3000);
    wr(ca(2, OFS_MPTR), 32'h4000);
    wr(ca(2, OFS_COUNT), 32'h1);
    wr(ca(2, OFS_SETUP), 32'h4033);
    wait_wr(n0 + 3);
    rdc(ca(2, OFS_COUNT), 32'h1, "reload");
    chk("dst", 32'h3000, u_bus.wa[n0 + 2]);
    chk("src", 32'hBFFF_4000, u_bus.wd[n0 + 2]);
    chk("done irq", 32'h4, 32'(chan_irq));
    wr(ca(2, OFS_SETUP), 32'h0);
    rdc(ca(2, OFS_SETUP), 32'h0, "off");
    wr(OFS_CLEAR, 32'h100);
    rdc(OFS_FLAGS, 32'h0, "clr ch2");
  endtask
  // bus error on the source read
  task automatic t_err;
    int n0;
    wr(ca(3, OFS_COUNT), 32'h3);
    fail <= 1'b1;
    periph_req[3] <= 1'b1;
    wr(ca(3, OFS_SETUP), 32'h9);
    poll(ca(3, OFS_SETUP), 32'h8);
    n0 = u_bus.n_ack;
    rdc(OFS_FLAGS, 32'h9000, "fault");
    rdc(ca(3, OFS_COUNT), 32'h3, "not counted");
    chk("fault irq", 32'h8, 32'(chan_irq));
    chk("stopped", 32'(n0), 32'(u_bus.n_ack));
    fail <= 1'b0;
    periph_req[3] <= 1'b0;
    wr(OFS_CLEAR, 32'h1000);
    rdc(OFS_FLAGS, 32'h0, "clr ch3");
  endtask
  // five channels requesting at once, all four priority codes
  task automatic t_prio;
    int n0;
    int c[5] = '{4, 5, 6, 7, 1};
    logic [31:0] p[5] = '{32'h1, 32'h1, 32'h3001, 32'h2001, 32'h1001};
    int ord[5] = '{6, 7, 1, 4, 5};
    n0 = u_bus.wa.size();
    for (int i = 0; i < 5; i++) begin
      wr(ca(c[i], OFS_MPTR), 32'h100 * c[i]);
      wr(ca(c[i], OFS_COUNT), 32'h1);
      wr(ca(c[i], OFS_SETUP), p[i]);
    end
    periph_req <= 8'hF2;
    wait_wr(n0 + 5);
    for (int i = 0; i < 5; i++) chk("grant", 32'h100 * ord[i], u_bus.wa[n0 + i]);
    periph_req <= 8'h00;
    wr(OFS_CLEAR, 32'hFFFF_FFFF);
    rdc(OFS_FLAGS, 32'h0, "clr every ch");
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_regs();
    t_p2m();
    t_copy();
    t_err();
    t_prio();
    final_report();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
